// File: core/branch_trace_pkg.sv
package branch_trace_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int ADDR_W = 32;                    // Instruction address width
  localparam int FIFO_DEPTH = 8;                 // Trace message buffer depth
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000; // Record reset value

  // ==========================================================================
  // Event kinds presented by the core
  // ==========================================================================
  typedef enum logic [2:0] {
    EV_BRANCH = 3'b000,  // Taken branch
    EV_EXCEPT = 3'b001,  // Exception or fault
    EV_CALL_FAULT = 3'b010, // Call that faulted
    EV_SOFT_INT = 3'b011, // Software interrupt
    EV_MGMT_INT = 3'b100 // System management interrupt serviced
  } event_kind_t;

  // ==========================================================================
  // Message output state machine
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,     // Waiting for buffered message
    ST_HOLD = 2'b01      // Presenting message to bus, waiting for accept
  } send_state_t;

endpackage

// File: core/trace_fifo.sv
`timescale 1ns/1ps
// ============================================================================
// Trace message FIFO
// ============================================================================
module trace_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Write side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [PW-1:0] wr_ptr;          // Write index
  logic [PW-1:0] rd_ptr;          // Read index
  logic [PW:0] count;             // Fill level
  logic do_wr;                    // Write this cycle
  logic do_rd;                    // Read this cycle

  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = o_rd_valid && i_rd_ready;
  assign o_wr_ready = (count != (PW+1)'(DEPTH));
  assign o_rd_valid = (count != '0);
  assign o_rd_data = mem[rd_ptr];

  // Storage write
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  // Pointers and level
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end

  // Level never passes depth
  a_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (i_reset)
    count <= (PW+1)'(DEPTH)) else $error("fifo level above depth");

endmodule // trace_fifo

// File: core/trap_arbiter.sv
`timescale 1ns/1ps
// ============================================================================
// Branch trap versus trace message arbiter
// ============================================================================
module trap_arbiter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Enables
  input wire logic i_trap_enable,
  input wire logic i_msg_enable,
  // Branch event
  input wire logic i_branch,
  // Results
  output logic o_trap,
  output logic o_msg_req
);

  // Traps yield to messages when both are enabled
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_trap <= 1'b0;
      o_msg_req <= 1'b0;
    end else begin
      o_trap <= i_branch && i_trap_enable && !i_msg_enable; // R3 R4
      o_msg_req <= i_branch && i_msg_enable; // R3 R11
    end
  end

  // Trap never fires while messages are enabled
  a_trap_blocked: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_branch && i_msg_enable) |=> !o_trap) else $error("trap with messages on"); // R4

endmodule // trap_arbiter

// File: core/branch_trace_and_record_unit.sv
// Function
// R1: Management interrupt with messaging emits a message
// R2: Management interrupt message source is current address
// R3: Traps alone or messages alone work normally
// R4: Both enabled: messages only, traps ignored
// R5: Last-branch record holds source and destination
// R6: Before-exception record updates only on exceptions
// R7: Faulting call, soft interrupt leave it unchanged
// R8: Bus reinit invalidates before-exception record
// R9: Cache line fill never corrupts messages
// R10: Message carries source and destination fields
// R11: Cleared enables suppress messages and record updates
`timescale 1ns/1ps
module branch_trace_and_record_unit
  import branch_trace_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Enables
  input wire logic i_record_enable,
  input wire logic i_msg_enable,
  input wire logic i_trap_enable,
  // Core events
  input wire logic i_event_valid,
  input wire event_kind_t i_event_kind,
  input wire logic [AW-1:0] i_event_source,
  input wire logic [AW-1:0] i_event_dest,
  // Asynchronous bus reinitialization pin
  input wire logic i_bus_reinit_request,
  // Cache fill path
  input wire logic i_fill_valid,
  input wire logic [2*AW-1:0] i_fill_data,
  // Bus message port
  output logic o_msg_valid,
  input wire logic i_msg_accept,
  output logic [AW-1:0] o_msg_source,
  output logic [AW-1:0] o_msg_dest,
  // Cache line store port
  output logic o_line_write,
  output logic [2*AW-1:0] o_line_data,
  // Records
  output logic [AW-1:0] o_last_branch_source,
  output logic [AW-1:0] o_last_branch_dest,
  output logic [AW-1:0] o_before_exc_source,
  output logic [AW-1:0] o_before_exc_dest,
  output logic o_before_exc_valid,
  // Trap and status
  output logic o_branch_trap,
  output logic o_msg_overflow
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic reinit_meta;             // Synchroniser first stage
  logic reinit_sync;             // Synchronised reinit level
  logic reinit_prev;             // Previous synced level
  logic is_branch_ev;            // Event is a branch-like transfer
  logic is_exception_ev;         // Event is a true exception
  logic arb_msg_req;             // Branch message request from arbiter
  logic arb_trap;                // Trap from arbiter
  logic [AW-1:0] ev_src_d;       // Delayed event source
  logic [AW-1:0] ev_dst_d;       // Delayed event destination
  logic mgmt_req;                // Message request for a management interrupt
  logic [AW-1:0] mgmt_src;       // Management interrupt message source
  logic [AW-1:0] mgmt_dst;       // Management interrupt message destination
  logic push_valid;              // FIFO write valid
  logic push_ready;              // FIFO write ready
  logic [2*AW-1:0] push_data;    // FIFO write word
  logic pop_valid;               // FIFO read valid
  logic pop_ready;               // FIFO read ready
  logic [2*AW-1:0] pop_data;     // FIFO read word
  send_state_t state;            // Bus send state

  // ==========================================================================
  // Bus reinit synchroniser
  // ==========================================================================
  // Two flip-flops before use
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      reinit_meta <= 1'b0;
      reinit_sync <= 1'b0;
      reinit_prev <= 1'b0;
    end else begin
      reinit_meta <= i_bus_reinit_request;
      reinit_sync <= reinit_meta;
      reinit_prev <= reinit_sync;
    end
  end

  // ==========================================================================
  // Event classification
  // ==========================================================================
  assign is_branch_ev = i_event_valid && (i_event_kind == EV_BRANCH);
  assign is_exception_ev = i_event_valid && (i_event_kind == EV_EXCEPT);

  // ==========================================================================
  // Last-branch record
  // ==========================================================================
  // Any branch, exception or interrupt updates it when enabled
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_last_branch_source <= AW'(ADDR_RESET);
      o_last_branch_dest <= AW'(ADDR_RESET);
    end else if (i_event_valid && i_record_enable) begin // R11
      o_last_branch_source <= i_event_source; // R5
      o_last_branch_dest <= i_event_dest; // R5
    end
  end

  // ==========================================================================
  // Last-branch-before-exception record
  // ==========================================================================
  // Copies the prior last-branch record on a true exception only
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_before_exc_source <= AW'(ADDR_RESET);
      o_before_exc_dest <= AW'(ADDR_RESET);
    end else if (is_exception_ev && i_record_enable) begin // R6 R7 R11
      o_before_exc_source <= o_last_branch_source; // R6
      o_before_exc_dest <= o_last_branch_dest; // R6
    end
  end

  // Validity: cleared on a bus reinit edge, set again by next exception
  // A fresh exception in the reinit cycle wins: its copy is taken after the upset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_before_exc_valid <= 1'b0;
    end else if (is_exception_ev && i_record_enable) begin
      o_before_exc_valid <= 1'b1; // R6
    end else if (reinit_sync && !reinit_prev) begin
      o_before_exc_valid <= 1'b0; // R8
    end
  end

  // ==========================================================================
  // Trap arbitration
  // ==========================================================================
  trap_arbiter u_arb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_trap_enable(i_trap_enable),
    .i_msg_enable(i_msg_enable),
    .i_branch(is_branch_ev),
    .o_trap(arb_trap),
    .o_msg_req(arb_msg_req)
  );

  // Trap output register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_branch_trap <= 1'b0;
    end else begin
      o_branch_trap <= arb_trap; // R3 R4
    end
  end

  // Branch event fields aligned with arbiter latency
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ev_src_d <= AW'(ADDR_RESET);
      ev_dst_d <= AW'(ADDR_RESET);
    end else if (is_branch_ev) begin
      ev_src_d <= i_event_source;
      ev_dst_d <= i_event_dest;
    end
  end

  // ==========================================================================
  // Management interrupt message capture
  // ==========================================================================
  // Source is the instruction running at service, not the previous message
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mgmt_req <= 1'b0;
      mgmt_src <= AW'(ADDR_RESET);
      mgmt_dst <= AW'(ADDR_RESET);
    end else begin
      mgmt_req <= i_event_valid && (i_event_kind == EV_MGMT_INT) && i_msg_enable; // R1 R11
      if (i_event_valid && (i_event_kind == EV_MGMT_INT)) begin
        mgmt_src <= i_event_source; // R2
        mgmt_dst <= i_event_dest;
      end
    end
  end

  // ==========================================================================
  // Message buffer
  // ==========================================================================
  // Source in upper half, destination in lower half; interrupt has priority
  assign push_valid = mgmt_req || arb_msg_req;
  assign push_data = mgmt_req ? {mgmt_src, mgmt_dst} : {ev_src_d, ev_dst_d}; // R10

  trace_fifo #(
    .WIDTH(2*AW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_wr_valid(push_valid),
    .o_wr_ready(push_ready),
    .i_wr_data(push_data),
    .o_rd_valid(pop_valid),
    .i_rd_ready(pop_ready),
    .o_rd_data(pop_data)
  );

  // Overflow flag: message lost because buffer full or both requests at once
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_msg_overflow <= 1'b0;
    end else if ((push_valid && !push_ready) || (mgmt_req && arb_msg_req)) begin
      o_msg_overflow <= 1'b1;
    end
  end

  // ==========================================================================
  // Bus send path
  // ==========================================================================
  // Message register loaded only from the buffer, separate from fill path
  assign pop_ready = (state == ST_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
      o_msg_valid <= 1'b0;
      o_msg_source <= AW'(ADDR_RESET);
      o_msg_dest <= AW'(ADDR_RESET);
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (pop_valid) begin
            o_msg_source <= pop_data[2*AW-1:AW]; // R9 R10
            o_msg_dest <= pop_data[AW-1:0]; // R9 R10
            o_msg_valid <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (i_msg_accept) begin
            o_msg_valid <= 1'b0;
            state <= ST_IDLE;
          end
        end
        // Unused codes fall back to idle
        default: begin
          o_msg_valid <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Cache line fill has its own store path
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_line_write <= 1'b0;
      o_line_data <= '0;
    end else begin
      o_line_write <= i_fill_valid; // R9
      if (i_fill_valid) begin
        o_line_data <= i_fill_data; // R9
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_mgmt_msg_request: assert property (@(posedge i_clk) disable iff (i_reset) // R1
    (i_event_valid && i_event_kind == EV_MGMT_INT && i_msg_enable) |=> mgmt_req)
    else $error("no message request for management interrupt");

  a_mgmt_source_addr: assert property (@(posedge i_clk) disable iff (i_reset) // R2
    (i_event_valid && i_event_kind == EV_MGMT_INT) |=> mgmt_src == $past(i_event_source))
    else $error("management interrupt source address wrong");

  a_trap_alone_works: assert property (@(posedge i_clk) disable iff (i_reset) // R3
    (is_branch_ev && i_trap_enable && !i_msg_enable) |-> ##2 o_branch_trap)
    else $error("trap missing with traps alone");

  a_trap_ignored: assert property (@(posedge i_clk) disable iff (i_reset) // R4
    (is_branch_ev && i_msg_enable) |-> ##2 !o_branch_trap)
    else $error("trap raised while messages enabled");

  a_last_branch_upd: assert property (@(posedge i_clk) disable iff (i_reset) // R5
    (i_event_valid && i_record_enable) |=>
    (o_last_branch_source == $past(i_event_source)
     && o_last_branch_dest == $past(i_event_dest)))
    else $error("last-branch record not updated");

  a_before_exc_hold: assert property (@(posedge i_clk) disable iff (i_reset) // R6 R7
    !is_exception_ev |=> $stable(o_before_exc_source) && $stable(o_before_exc_dest))
    else $error("before-exception record changed without exception");

  a_before_exc_copy: assert property (@(posedge i_clk) disable iff (i_reset) // R6
    (is_exception_ev && i_record_enable) |=>
    o_before_exc_source == $past(o_last_branch_source))
    else $error("before-exception record not the prior branch");

  a_reinit_invalid: assert property (@(posedge i_clk) disable iff (i_reset) // R8
    (reinit_sync && !reinit_prev && !(is_exception_ev && i_record_enable))
    |=> !o_before_exc_valid)
    else $error("record still valid after bus reinit");

  a_msg_stable: assert property (@(posedge i_clk) disable iff (i_reset) // R9
    (o_msg_valid && !i_msg_accept) |=> $stable(o_msg_source) && $stable(o_msg_dest))
    else $error("message changed while presented");

  a_record_disabled: assert property (@(posedge i_clk) disable iff (i_reset) // R11
    !i_record_enable |=> $stable(o_last_branch_source))
    else $error("record updated while disabled");

endmodule // branch_trace_and_record_unit

// File: tb/trace_bus_agent.sv
`timescale 1ns/1ps
// ============================================================================
// Bus agent that takes trace messages, promptly or after a stall
// ============================================================================
module trace_bus_agent
  import branch_trace_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Message port
  input wire logic i_msg_valid,
  input wire logic [ADDR_W-1:0] i_msg_source,
  input wire logic [ADDR_W-1:0] i_msg_dest,
  output logic o_msg_accept
);
  int stall = 0; // Cycles to wait before accepting
  int wait_cnt = 0; // Cycles the offered message has waited
  logic [ADDR_W-1:0] rx_src[$]; // Received source fields
  logic [ADDR_W-1:0] rx_dst[$]; // Received destination fields

  // Accept only while a message is offered, hold until it is taken
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_msg_accept <= 1'b0;
      wait_cnt <= 0;
    end else if (i_msg_valid && o_msg_accept) begin
      rx_src.push_back(i_msg_source);
      rx_dst.push_back(i_msg_dest);
      o_msg_accept <= 1'b0;
      wait_cnt <= 0;
    end else if (i_msg_valid) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= stall) begin
        o_msg_accept <= 1'b1;
      end
    end else begin
      o_msg_accept <= 1'b0;
      wait_cnt <= 0;
    end
  end
endmodule // trace_bus_agent

// File: tb/tb.sv
`timescale 1ns/1ps
// ============================================================================
// Branch trace and record unit testbench
// ============================================================================
module tb;
  import branch_trace_pkg::*;
  logic i_clk, i_reset, i_record_enable, i_msg_enable, i_trap_enable, i_event_valid;
  event_kind_t i_event_kind;
  logic [ADDR_W-1:0] i_event_source, i_event_dest, o_msg_source, o_msg_dest;
  logic [ADDR_W-1:0] o_last_branch_source, o_last_branch_dest;
  logic [ADDR_W-1:0] o_before_exc_source, o_before_exc_dest;
  logic i_bus_reinit_request, i_fill_valid, o_msg_valid, i_msg_accept, o_line_write;
  logic o_before_exc_valid, o_branch_trap, o_msg_overflow;
  logic [2*ADDR_W-1:0] i_fill_data, o_line_data, line_seen;
  int fails = 0;
  int n_compared = 0;
  int ntrap, nline;

  branch_trace_and_record_unit #(.AW(ADDR_W), .DEPTH(FIFO_DEPTH)) i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_record_enable(i_record_enable),
    .i_msg_enable(i_msg_enable), .i_trap_enable(i_trap_enable),
    .i_event_valid(i_event_valid), .i_event_kind(i_event_kind),
    .i_event_source(i_event_source), .i_event_dest(i_event_dest),
    .i_bus_reinit_request(i_bus_reinit_request), .i_fill_valid(i_fill_valid),
    .i_fill_data(i_fill_data), .o_msg_valid(o_msg_valid), .i_msg_accept(i_msg_accept),
    .o_msg_source(o_msg_source), .o_msg_dest(o_msg_dest), .o_line_write(o_line_write),
    .o_line_data(o_line_data), .o_last_branch_source(o_last_branch_source),
    .o_last_branch_dest(o_last_branch_dest), .o_before_exc_source(o_before_exc_source),
    .o_before_exc_dest(o_before_exc_dest), .o_before_exc_valid(o_before_exc_valid),
    .o_branch_trap(o_branch_trap), .o_msg_overflow(o_msg_overflow));

  trace_bus_agent i_agent (
    .i_clk(i_clk), .i_reset(i_reset), .i_msg_valid(o_msg_valid),
    .i_msg_source(o_msg_source), .i_msg_dest(o_msg_dest), .o_msg_accept(i_msg_accept));

  // ==========================================================================
  // Clock, watchdog and compare tasks
  // ==========================================================================
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Whole run needs under 300 cycles; cut a hang well beyond that
  initial begin
    #(5 * 20000);
    fails++;
    final_report();
  end

  task automatic check_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Present one event for one edge; valid stays up for back-to-back use
  task automatic send_evt(input event_kind_t k, input logic [31:0] s, input logic [31:0] d);
    i_event_valid = 1'b1;
    i_event_kind = k;
    i_event_source = s;
    i_event_dest = d;
    @(negedge i_clk);
  endtask

  // Release strobes and let cycles pass, counting trap pulses
  task automatic idle(input int n);
    i_event_valid = 1'b0;
    i_fill_valid = 1'b0;
    repeat (n) begin
      if (o_branch_trap === 1'b1) ntrap++;
      if (o_line_write === 1'b1) begin
        nline++;
        line_seen = o_line_data;
      end
      @(negedge i_clk);
    end
  endtask

  // Drop any message still under way
  task automatic flush();
    idle(20);
    i_agent.rx_src.delete();
    i_agent.rx_dst.delete();
  endtask

  // Wait a bounded time for the next message and compare its fields
  task automatic expect_msg(input logic [31:0] s, input logic [31:0] d);
    int i;
    for (i = 0; i < 60 && i_agent.rx_src.size() == 0; i++) @(negedge i_clk);
    if (i_agent.rx_src.size() == 0) begin
      check_flag(1'b0, 1'b1);
    end else begin
      check_addr(i_agent.rx_src.pop_front(), s);
      check_addr(i_agent.rx_dst.pop_front(), d);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    {i_record_enable, i_msg_enable, i_trap_enable, i_event_valid} = 4'h0;
    {i_bus_reinit_request, i_fill_valid} = 2'h0;
    i_event_kind = EV_BRANCH;
    {i_event_source, i_event_dest, i_fill_data} = '0;
    i_reset = 1'b1;
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    // Reset state
    check_addr(o_last_branch_source, ADDR_RESET);
    check_addr(o_before_exc_dest, ADDR_RESET);
    check_flag(o_before_exc_valid, 1'b0);
    check_flag(o_msg_valid | o_branch_trap | o_msg_overflow, 1'b0);
    // Branch with both traps and messages on
    {i_record_enable, i_msg_enable, i_trap_enable} = 3'h7;
    ntrap = 0;
    send_evt(EV_BRANCH, 32'h0000_1000, 32'h0000_2000);
    idle(8);
    check_addr(o_last_branch_source, 32'h0000_1000);
    check_addr(o_last_branch_dest, 32'h0000_2000);
    check_flag(ntrap == 0, 1'b1);
    expect_msg(32'h0000_1000, 32'h0000_2000);
    // Traps alone
    i_msg_enable = 1'b0;
    ntrap = 0;
    send_evt(EV_BRANCH, 32'h0000_3000, 32'h0000_4000);
    idle(20);
    check_flag(ntrap == 1, 1'b1);
    check_flag(i_agent.rx_src.size() == 0, 1'b1);
    i_msg_enable = 1'b1;
    // Exception copies the prior last-branch record
    send_evt(EV_EXCEPT, 32'h0000_5000, 32'h0000_6000);
    idle(2);
    check_addr(o_before_exc_source, 32'h0000_3000);
    check_addr(o_before_exc_dest, 32'h0000_4000);
    check_flag(o_before_exc_valid, 1'b1);
    check_addr(o_last_branch_source, 32'h0000_5000);
    // Faulting call and soft interrupt leave the before-exception record
    for (int i = 0; i < 2; i++) begin
      send_evt(i == 0 ? EV_CALL_FAULT : EV_SOFT_INT, 32'h0000_7000 + i, 32'h0000_8000 + i);
      idle(2);
      check_addr(o_last_branch_dest, 32'h0000_8000 + i);
      check_addr(o_before_exc_source, 32'h0000_3000);
    end
    // Records frozen when disabled
    i_record_enable = 1'b0;
    send_evt(EV_BRANCH, 32'h0000_D000, 32'h0000_E000);
    send_evt(EV_EXCEPT, 32'h0000_D100, 32'h0000_E100);
    idle(2);
    check_addr(o_last_branch_source, 32'h0000_7001);
    check_addr(o_before_exc_dest, 32'h0000_4000);
    i_record_enable = 1'b1;
    // Bus reinit invalidates, next exception revalidates
    i_bus_reinit_request = 1'b1;
    idle(6);
    check_flag(o_before_exc_valid, 1'b0);
    i_bus_reinit_request = 1'b0;
    idle(4);
    send_evt(EV_EXCEPT, 32'h0000_F000, 32'h0000_F100);
    idle(2);
    check_flag(o_before_exc_valid, 1'b1);
    check_addr(o_before_exc_source, 32'h0000_7001);
    // Branch then management interrupt back to back
    flush();
    send_evt(EV_BRANCH, 32'h0000_B000, 32'h0000_C000);
    send_evt(EV_MGMT_INT, 32'h0000_9000, 32'h0000_A000);
    idle(1);
    expect_msg(32'h0000_B000, 32'h0000_C000);
    expect_msg(32'h0000_9000, 32'h0000_A000);
    // Line fill in the same cycle as a branch
    flush();
    nline = 0;
    i_fill_valid = 1'b1;
    i_fill_data = 64'h1234_5678_9ABC_DEF0;
    send_evt(EV_BRANCH, 32'h0001_0000, 32'h0002_0000);
    idle(4);
    check_flag(nline == 1, 1'b1);
    check_addr(line_seen[63:32], 32'h1234_5678);
    check_addr(line_seen[31:0], 32'h9ABC_DEF0);
    expect_msg(32'h0001_0000, 32'h0002_0000);
    // Stalled bus: fill the buffer until it refuses, then drain
    flush();
    i_agent.stall = 100000;
    for (int i = 0; i < 12; i++) send_evt(EV_BRANCH, 32'h0010_0000 + i, 32'h0020_0000 + i);
    idle(20);
    check_flag(o_msg_overflow, 1'b1);
    i_agent.stall = 2;
    // One message waits in the output register, eight in the buffer
    for (int i = 0; i < 9; i++) expect_msg(32'h0010_0000 + i, 32'h0020_0000 + i);
    final_report();
  end
endmodule // tb
